// ### rtl/cgar_defs.svh
`ifndef CGAR_DEFS_SVH
`define CGAR_DEFS_SVH

`define CGAR_OFS_BUS_HI     8'h22
`define CGAR_OFS_BUS_LO     8'h23
`define CGAR_OFS_BAT_HI     8'h24
`define CGAR_OFS_BAT_LO     8'h25
`define CGAR_OFS_DIE_HI     8'h26
`define CGAR_OFS_DIE_LO     8'h27
`define CGAR_OFS_BUS_FLT    8'h28
`define CGAR_OFS_BAT_FLT    8'h29
`define CGAR_OFS_DIE_ALM    8'h2A
`define CGAR_OFS_CHARGE_CONTROL   8'h2B
`define CGAR_OFS_OVP_STAT   8'h2C
`define CGAR_OFS_OVP_FLAG   8'h2D
`define CGAR_OFS_DEGLITCH   8'h2E

`define CGAR_RST_BUS_FLT    8'h15
`define CGAR_RST_BAT_FLT    8'h15
`define CGAR_RST_DIE_ALM    8'hC8
`define CGAR_RST_RESULT     16'h0000

`define CGAR_DIE_ALM_MIN    8'h00
`define CGAR_DIE_ALM_MAX    8'hC8

`define CGAR_CC_SS_MSB      7
`define CGAR_CC_SS_LSB      5
`define CGAR_CC_OVP_DIS     3
`define CGAR_CC_UCP_SEL     2
`define CGAR_CC_SNS_SEL     1
`define CGAR_CC_PD_EN       0
`define CGAR_OVP_LIVE_BIT   0
`define CGAR_OVP_FLAG_BIT   4
`define CGAR_OVP_MASK_BIT   0
`define CGAR_DG_BUSLO_BIT   4
`define CGAR_DG_IBUSLO_BIT  3

`define CGAR_CLK_MHZ        250
`define CGAR_PD_US          10
`define CGAR_PD_CYC         (`CGAR_PD_US * `CGAR_CLK_MHZ)
`define CGAR_MS_CYC         (1000 * `CGAR_CLK_MHZ)
`define CGAR_ALARM_WIN_PCT  5

`endif

// ### rtl/cgar_pkg.sv
package cgar_pkg;

  typedef struct packed {
    logic        sign;
    logic [14:0] mag;
  } cgar_result_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cgar_reg_req_t;

  typedef struct packed {
    logic [2:0] ss_timeout_sel;
    logic       output_overvolt_disable;
    logic       input_undercurrent_rise_sel;
    logic       sense_resistor_sel;
    logic       input_pulldown_enable;
    logic       bus_low_error_deglitch_sel;
    logic       input_current_low_deglitch_sel;
  } cgar_ctrl_t;

  typedef enum logic [1:0] {
    CGAR_SS_IDLE,
    CGAR_SS_WAIT,
    CGAR_SS_DONE,
    CGAR_SS_FAULT
  } cgar_ss_state_t;

endpackage

// ### rtl/cgar_regs.sv
`timescale 1ns/10ps
`default_nettype none
`include "cgar_defs.svh"

module cgar_regs #(
  parameter int unsigned PD_CYCLES  = `CGAR_PD_CYC,
  parameter int unsigned MS_CYCLES  = `CGAR_MS_CYC,
  parameter int unsigned US_CYCLES  = `CGAR_CLK_MHZ
) (
  input  wire logic                   core_clk,
  input  wire logic                   reset,
  input  wire logic                   reg_reset,
  input  wire cgar_pkg::cgar_reg_req_t req,
  output logic [7:0]                  rdata,
  input  wire cgar_pkg::cgar_result_t bus_conn_sense_result,
  input  wire cgar_pkg::cgar_result_t battery_sense_result,
  input  wire cgar_pkg::cgar_result_t die_temp_result,
  input  wire logic                   result_valid,
  input  wire logic                   output_overvolt_condition,
  input  wire logic                   switching_start,
  input  wire logic                   input_bus_current_above,
  input  wire logic                   bus_low_raw,
  input  wire logic                   input_current_low_raw,
  output cgar_pkg::cgar_ctrl_t        ctrl,
  output logic                        thermal_sense_alarm,
  output logic                        output_overvolt_irq,
  output logic                        output_overvolt_protect_en,
  output logic                        external_protection_input_pd,
  output logic                        soft_start_fault,
  output logic                        bus_low_error,
  output logic                        input_current_low
);
  import cgar_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Input synchronisers for analogue comparator levels.
  // Only the second stage is read; the first may still be settling.

  logic [1:0] ovp_sync;
  logic [1:0] cur_sync;
  logic [1:0] blo_sync;
  logic [1:0] ilo_sync;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ovp_sync <= 2'h0;
      cur_sync <= 2'h0;
      blo_sync <= 2'h0;
      ilo_sync <= 2'h0;
    end else begin
      ovp_sync <= {ovp_sync[0], output_overvolt_condition};
      cur_sync <= {cur_sync[0], input_bus_current_above};
      blo_sync <= {blo_sync[0], bus_low_raw};
      ilo_sync <= {ilo_sync[0], input_current_low_raw};
    end
  end
  wire ovp_live = ovp_sync[1];

  //////////////////////////////////////////////////////////////////////////
  // Register storage.

  cgar_result_t res_bus;
  cgar_result_t res_bat;
  cgar_result_t res_die;
  logic [7:0]   bus_conn_fault_level;
  logic [7:0]   battery_fault_level;
  logic [7:0]   die_alarm_level;
  logic [7:0]   hi_shadow_lo;
  logic         output_overvolt_latched;
  logic         output_overvolt_irq_mask;
  logic         pd_done;
  // The control register reads these two before their own sections.
  cgar_ss_state_t ss_state;

  wire soft_rst = reset | reg_reset;
  wire wr_bus   = req.wr && req.addr == `CGAR_OFS_BUS_FLT;
  wire wr_bat   = req.wr && req.addr == `CGAR_OFS_BAT_FLT;
  wire wr_die   = req.wr && req.addr == `CGAR_OFS_DIE_ALM;
  wire wr_cc    = req.wr && req.addr == `CGAR_OFS_CHARGE_CONTROL;
  wire wr_msk   = req.wr && req.addr == `CGAR_OFS_OVP_FLAG;
  wire wr_dg    = req.wr && req.addr == `CGAR_OFS_DEGLITCH;
  wire rd_flag  = req.rd && req.addr == `CGAR_OFS_OVP_FLAG;
  wire rd_bus_h = req.rd && req.addr == `CGAR_OFS_BUS_HI;
  wire rd_bat_h = req.rd && req.addr == `CGAR_OFS_BAT_HI;
  wire rd_die_h = req.rd && req.addr == `CGAR_OFS_DIE_HI;

  // Values above the top of the scale are pulled back to it.
  // The lower bound is kept so that the limits can be moved.
  wire [7:0] die_clamped =
    (req.wdata > `CGAR_DIE_ALM_MAX) ? `CGAR_DIE_ALM_MAX :
    (req.wdata < `CGAR_DIE_ALM_MIN) ? `CGAR_DIE_ALM_MIN :
    req.wdata;

  // Results are cleared and thresholds set back to their defaults by either reset; no watchdog input.
  always_ff @(posedge core_clk) begin
    if (soft_rst) begin
      res_bus              <= `CGAR_RST_RESULT;
      res_bat              <= `CGAR_RST_RESULT;
      res_die              <= `CGAR_RST_RESULT;
      bus_conn_fault_level <= `CGAR_RST_BUS_FLT;
      battery_fault_level  <= `CGAR_RST_BAT_FLT;
      die_alarm_level      <= `CGAR_RST_DIE_ALM;
    end else begin
      if (result_valid) begin
        res_bus <= bus_conn_sense_result;
        res_bat <= battery_sense_result;
        res_die <= die_temp_result;
      end
      if (wr_bus)
        bus_conn_fault_level <= req.wdata;
      if (wr_bat)
        battery_fault_level <= req.wdata;
      if (wr_die)
        die_alarm_level <= die_clamped;
    end
  end

  // Reading a high byte freezes its low byte in one shadow shared by all three results, so a pair read back to back is not torn.
  always_ff @(posedge core_clk) begin
    if (soft_rst) begin
      hi_shadow_lo <= 8'h00;
    end else if (rd_bus_h) begin
      hi_shadow_lo <= res_bus.mag[7:0];
    end else if (rd_bat_h) begin
      hi_shadow_lo <= res_bat.mag[7:0];
    end else if (rd_die_h) begin
      hi_shadow_lo <= res_die.mag[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Control register: only some bits follow the register reset.

  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl <= '0;
    end else begin
      if (reg_reset) begin
        ctrl.input_undercurrent_rise_sel <= 1'b0;
        ctrl.input_pulldown_enable       <= 1'b0;
        ctrl.bus_low_error_deglitch_sel  <= 1'b0;
        ctrl.input_current_low_deglitch_sel <= 1'b0;
      end else if (wr_cc) begin
        ctrl.ss_timeout_sel <= req.wdata[`CGAR_CC_SS_MSB:`CGAR_CC_SS_LSB];
        ctrl.output_overvolt_disable <= req.wdata[`CGAR_CC_OVP_DIS];
        ctrl.sense_resistor_sel <= req.wdata[`CGAR_CC_SNS_SEL];
        ctrl.input_pulldown_enable <= req.wdata[`CGAR_CC_PD_EN];
        // Ignored once switching has begun.
        if (ss_state == CGAR_SS_IDLE)
          ctrl.input_undercurrent_rise_sel <= req.wdata[`CGAR_CC_UCP_SEL];
      end else if (wr_dg) begin
        ctrl.bus_low_error_deglitch_sel <= req.wdata[`CGAR_DG_BUSLO_BIT];
        ctrl.input_current_low_deglitch_sel <=
          req.wdata[`CGAR_DG_IBUSLO_BIT];
      end
      if (pd_done)
        ctrl.input_pulldown_enable <= 1'b0;
      if (wr_cc && ctrl.output_overvolt_disable == 1'b0)
        ctrl.sense_resistor_sel <= req.wdata[`CGAR_CC_SNS_SEL];
    end
  end
  assign output_overvolt_protect_en = ~ctrl.output_overvolt_disable;

  //////////////////////////////////////////////////////////////////////////
  // Output overvoltage flag and mask.
  // The mask only gates the interrupt; the flag itself still latches.

  always_ff @(posedge core_clk) begin
    if (reset) begin
      output_overvolt_latched  <= 1'b0;
      output_overvolt_irq_mask <= 1'b0;
    end else begin
      // A live condition keeps the flag set even across a read.
      if (ovp_live)
        output_overvolt_latched <= 1'b1;
      else if (rd_flag)
        output_overvolt_latched <= 1'b0;
      if (reg_reset)
        output_overvolt_irq_mask <= 1'b0;
      else if (wr_msk)
        output_overvolt_irq_mask <= req.wdata[`CGAR_OVP_MASK_BIT];
    end
  end
  assign output_overvolt_irq = output_overvolt_latched &
                               ~output_overvolt_irq_mask &
                               ~ctrl.output_overvolt_disable;

  //////////////////////////////////////////////////////////////////////////
  // Thermal-sense alarm: sense in 0.09766% steps, threshold in 0.19531%,
  // so threshold code times two is in sense units; 5% is 51 sense steps.

  localparam logic [15:0] WIN = 16'd51;
  wire [15:0] bus_thr = {7'h00, bus_conn_fault_level, 1'b0};
  wire [15:0] bat_thr = {7'h00, battery_fault_level, 1'b0};
  // A negative reading is taken as zero; this still alarms for threshold codes up to 25.
  wire [15:0] bus_val = res_bus.sign ? 16'h0000 : {1'b0, res_bus.mag};
  wire [15:0] bat_val = res_bat.sign ? 16'h0000 : {1'b0, res_bat.mag};
  wire bus_near = (bus_val + WIN) >= bus_thr;
  wire bat_near = (bat_val + WIN) >= bat_thr;
  assign thermal_sense_alarm = bus_near | bat_near;

  //////////////////////////////////////////////////////////////////////////
  // Soft-start timeout: a microsecond tick drives a millisecond-class
  // counter; every step up to 1.5 s is counted in microseconds.

  logic [17:0] us_div;
  logic        us_tick;
  logic [23:0] ss_cnt;
  logic [23:0] ss_limit;
  always_comb begin
    case (ctrl.ss_timeout_sel)
      3'h1:    ss_limit = 24'd12500;
      3'h2:    ss_limit = 24'd25000;
      3'h3:    ss_limit = 24'd50000;
      3'h4:    ss_limit = 24'd100000;
      3'h5:    ss_limit = 24'd400000;
      3'h6:    ss_limit = 24'd1500000;
      3'h7:    ss_limit = 24'd10000000;
      default: ss_limit = 24'd0;
    endcase
  end
  // The 100 s setting counts tenfold slower units to stay in 24 bits.
  wire slow_unit = ctrl.ss_timeout_sel == 3'h7;

  logic [3:0] dec_cnt;
  always_ff @(posedge core_clk) begin
    if (reset || us_div == 18'(US_CYCLES - 1))
      us_div <= 18'h0;
    else
      us_div <= us_div + 18'h1;
  end
  assign us_tick = us_div == 18'(US_CYCLES - 1);
  wire unit_tick = us_tick && (!slow_unit || dec_cnt == 4'h9);

  // Idle is left only while switching is enabled and re-entered once it
  // stops in done or fault (not in wait), which is what reopens the undercurrent select for writing.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ss_state <= CGAR_SS_IDLE;
      ss_cnt   <= 24'h0;
      dec_cnt  <= 4'h0;
    end else begin
      if (us_tick)
        dec_cnt <= (dec_cnt == 4'h9) ? 4'h0 : dec_cnt + 4'h1;
      case (ss_state)
        CGAR_SS_IDLE: begin
          ss_cnt <= 24'h0;
          if (switching_start)
            ss_state <= CGAR_SS_WAIT;
        end
        CGAR_SS_WAIT: begin
          if (cur_sync[1])
            ss_state <= CGAR_SS_DONE;
          else if (ss_limit != 24'h0 && ss_cnt >= ss_limit)
            ss_state <= CGAR_SS_FAULT;
          else if (unit_tick)
            ss_cnt <= ss_cnt + 24'h1;
        end
        CGAR_SS_DONE,
        CGAR_SS_FAULT: begin
          if (!switching_start)
            ss_state <= CGAR_SS_IDLE;
        end
        default: ss_state <= CGAR_SS_IDLE;
      endcase
    end
  end
  assign soft_start_fault = ss_state == CGAR_SS_FAULT;

  //////////////////////////////////////////////////////////////////////////
  // Input pull-down pulse for a fixed interval, then the enable self-clears.

  logic [31:0] pd_cnt;
  // Setting the bit again does not restart a running interval; clearing
  // it ends the pulse at once.
  assign pd_done = ctrl.input_pulldown_enable && pd_cnt == PD_CYCLES - 1;
  always_ff @(posedge core_clk) begin
    if (reset || !ctrl.input_pulldown_enable)
      pd_cnt <= 32'h0;
    else
      pd_cnt <= pd_cnt + 32'h1;
  end
  assign external_protection_input_pd = ctrl.input_pulldown_enable;

  //////////////////////////////////////////////////////////////////////////
  // Deglitch filters: bus-low 10us/10ms, current-low 10us/5ms.
  // Any sample that agrees with the output restarts the count, so a
  // glitch shorter than the window never reaches the output.

  logic [31:0] blo_cnt;
  logic [31:0] ilo_cnt;
  wire [31:0] blo_lim = ctrl.bus_low_error_deglitch_sel ?
                        10 * MS_CYCLES : 10 * US_CYCLES;
  wire [31:0] ilo_lim = ctrl.input_current_low_deglitch_sel ?
                        5 * MS_CYCLES : 10 * US_CYCLES;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      blo_cnt           <= 32'h0;
      ilo_cnt           <= 32'h0;
      bus_low_error     <= 1'b0;
      input_current_low <= 1'b0;
    end else begin
      blo_cnt <= (blo_sync[1] == bus_low_error) ? 32'h0 : blo_cnt + 32'h1;
      ilo_cnt <= (ilo_sync[1] == input_current_low) ? 32'h0 : ilo_cnt + 32'h1;
      if (blo_cnt >= blo_lim - 1)
        bus_low_error <= blo_sync[1];
      if (ilo_cnt >= ilo_lim - 1)
        input_current_low <= ilo_sync[1];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read mux; reserved bits read zero.
  // Read data holds between reads, so the host may fetch it late.

  logic [7:0] next_rdata;
  always_comb begin
    case (req.addr)
      `CGAR_OFS_BUS_HI:   next_rdata = {res_bus.sign, res_bus.mag[14:8]};
      `CGAR_OFS_BUS_LO:   next_rdata = hi_shadow_lo;
      `CGAR_OFS_BAT_HI:   next_rdata = {res_bat.sign, res_bat.mag[14:8]};
      `CGAR_OFS_BAT_LO:   next_rdata = hi_shadow_lo;
      `CGAR_OFS_DIE_HI:   next_rdata = {res_die.sign, res_die.mag[14:8]};
      `CGAR_OFS_DIE_LO:   next_rdata = hi_shadow_lo;
      `CGAR_OFS_BUS_FLT:  next_rdata = bus_conn_fault_level;
      `CGAR_OFS_BAT_FLT:  next_rdata = battery_fault_level;
      `CGAR_OFS_DIE_ALM:  next_rdata = die_alarm_level;
      `CGAR_OFS_CHARGE_CONTROL: next_rdata = {ctrl.ss_timeout_sel, 1'b0,
                                        ctrl.output_overvolt_disable,
                                        ctrl.input_undercurrent_rise_sel,
                                        ctrl.sense_resistor_sel,
                                        ctrl.input_pulldown_enable};
      `CGAR_OFS_OVP_STAT: next_rdata = {7'h00, ovp_live};
      `CGAR_OFS_OVP_FLAG: next_rdata = {3'h0, output_overvolt_latched,
                                        3'h0, output_overvolt_irq_mask};
      `CGAR_OFS_DEGLITCH: next_rdata = {3'h0,
                                        ctrl.bus_low_error_deglitch_sel,
                                        ctrl.input_current_low_deglitch_sel,
                                        3'h0};
      default:            next_rdata = 8'h00;
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (reset)
      rdata <= 8'h00;
    else if (req.rd)
      rdata <= next_rdata;
  end

endmodule
`default_nettype wire

// ### test/cgar_regs_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module cgar_regs_monitor
  import cgar_pkg::*;
#(
  parameter int unsigned PD_CYCLES = 2500
) (
  input wire logic                    core_clk,
  input wire logic                    reset,
  input wire logic                    reg_reset,
  input wire cgar_pkg::cgar_reg_req_t req,
  input wire logic [7:0]              rdata,
  input wire logic                    output_overvolt_condition,
  input wire logic                    switching_start,
  input wire cgar_pkg::cgar_ctrl_t    ctrl,
  input wire logic                    output_overvolt_protect_en,
  input wire logic                    external_protection_input_pd
);
  logic [7:0] wd;
  logic [31:0] pd_run;
  wire logic  ovp    = output_overvolt_condition;
  wire logic  wr_ctl = req.wr && req.addr == 8'h2B && !reg_reset;
  wire logic  rd_ovp = req.rd && req.addr == 8'h2C;
  always_ff @(posedge core_clk) begin
    wd <= req.wdata;
    pd_run <= external_protection_input_pd ? pd_run + 32'h1 : 32'h0;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
////////////////////////////////////////////////////////////////////////////////
  a_protect_tracks_disable: assert property (
    output_overvolt_protect_en == !ctrl.output_overvolt_disable)
    else $error("protect enable disagrees with disable bit");
  a_ctrl_write_lands: assert property (
    wr_ctl |=> {ctrl.ss_timeout_sel, ctrl.output_overvolt_disable,
                ctrl.sense_resistor_sel} == {wd[7:5], wd[3], wd[1]})
    else $error("control write not applied");
  // Switching held for three cycles keeps the soft-start machine out of idle, whatever the timeout.
  a_ucp_write_refused: assert property (
    switching_start [*3] ##0 (wr_ctl && ctrl.ss_timeout_sel != 3'b000)
    |=> $stable(ctrl.input_undercurrent_rise_sel))
    else $error("undercurrent select changed while switching");
  a_pulldown_length: assert property (
    $fell(external_protection_input_pd) && !$past(reg_reset) &&
    !$past(req.wr && req.addr == 8'h2B) |->
    $past(pd_run) == PD_CYCLES - 1)
    else $error("pull-down interval has the wrong length");
  a_deglitch_write: assert property (
    req.wr && req.addr == 8'h2E && !reg_reset |=>
    {ctrl.bus_low_error_deglitch_sel,
     ctrl.input_current_low_deglitch_sel} == wd[4:3])
    else $error("deglitch select not applied");
  a_status_live_high: assert property (
    ovp [*4] ##0 rd_ovp |=> rdata == 8'h01)
    else $error("status low during overvoltage");
  a_status_live_low: assert property (
    !ovp [*4] ##0 rd_ovp |=> rdata == 8'h00)
    else $error("status high without overvoltage");
  a_flag_latch_read: assert property (
    ovp [*4] ##0 (req.rd && req.addr == 8'h2D) |=> rdata[4])
    else $error("flag clear during overvoltage");
  a_die_alarm_clamp: assert property (
    (req.wr && req.addr == 8'h2A && req.wdata > 8'hC8) ##2
    (req.rd && req.addr == 8'h2A) |=> rdata == 8'hC8)
    else $error("die alarm level not clamped");
endmodule

bind cgar_regs cgar_regs_monitor #(.PD_CYCLES(PD_CYCLES)) u_monitor (
  .core_clk, .reset, .reg_reset, .req, .rdata, .output_overvolt_condition,
  .switching_start, .ctrl, .output_overvolt_protect_en,
  .external_protection_input_pd
);
`default_nettype wire

// ### test/cgar_host.sv
`timescale 1ns/10ps
`default_nettype none
module cgar_host
  import cgar_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic [7:0]             rdata,
  output var cgar_pkg::cgar_reg_req_t req
);
  initial req = '0;
  // Changes to the undercurrent select are left to the caller: only one
  // scenario writes it while switching, on purpose.
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge core_clk);
    req <= '0;
    #1;
  endtask
  // The strobe is held over the taking edge; data is picked up after it.
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge core_clk);
    req <= '0;
    #1 v = rdata;
  endtask
endmodule
`default_nettype wire

// ### test/cgar_regs_test.sv
`timescale 1ns/10ps
`default_nettype none
module cgar_regs_test;
  import cgar_pkg::*;
  logic          core_clk, reset, reg_reset, result_valid, switching_start;
  logic          output_overvolt_condition, input_bus_current_above;
  logic          bus_low_raw, input_current_low_raw, quiet;
  cgar_reg_req_t req;
  logic [7:0]    rdata, d;
  cgar_result_t  bus_conn_sense_result, battery_sense_result, die_temp_result;
  cgar_result_t  res [3];
  cgar_ctrl_t    ctrl;
  logic          thermal_sense_alarm, output_overvolt_irq, soft_start_fault;
  logic          output_overvolt_protect_en, external_protection_input_pd;
  logic          bus_low_error, input_current_low;
  wire logic [1:0] dg = {bus_low_error, input_current_low};
  int            failures, cmp_count, cycles;
  logic [31:0]   lfsr, noise;
  int            ab [5] = '{300, 100, 100, 205, 204};
  int            at [5] = '{100, 100, 300, 100, 100};
  cgar_regs #(.PD_CYCLES(8), .MS_CYCLES(10), .US_CYCLES(2)) dut (
    .core_clk, .reset, .reg_reset, .req, .rdata, .bus_conn_sense_result,
    .battery_sense_result, .die_temp_result, .result_valid,
    .output_overvolt_condition, .switching_start, .input_bus_current_above,
    .bus_low_raw, .input_current_low_raw, .ctrl, .thermal_sense_alarm,
    .output_overvolt_irq, .output_overvolt_protect_en,
    .external_protection_input_pd, .soft_start_fault, .bus_low_error,
    .input_current_low);
  cgar_host host (.core_clk, .rdata, .req);
////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] step(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [7:0] clamp(input logic [7:0] v);
    return (v > 8'hC8) ? 8'hC8 : v;
  endfunction
  function automatic logic near(input int s, input logic [7:0] t);
    return s + 51 >= 2 * int'(t);
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                       input string what);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen,
               exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    host.rd(a, v);
    check({8'h00, v}, {8'h00, e}, "read");
  endtask
  task automatic load(input cgar_result_t a, b, c);
    @(posedge core_clk);
    bus_conn_sense_result <= a;
    battery_sense_result <= b;
    die_temp_result <= c;
    result_valid <= 1'b1;
    @(posedge core_clk);
    result_valid <= 1'b0;
  endtask
  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
////////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // The raw low-level inputs wiggle until the deglitch test holds them.
  always @(posedge core_clk) begin
    noise <= step(noise);
    if (!quiet) begin
      bus_low_raw <= noise[3];
      input_current_low_raw <= noise[9];
    end
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      failures++;
      conclude();
    end
  end
  initial begin
    failures = 0;
    cmp_count = 0;
    cycles = 0;
    lfsr = 32'hE528;
    noise = 32'hE528;
    {reset, reg_reset, result_valid, switching_start} = 4'h8;
    {output_overvolt_condition, input_bus_current_above} = 2'h0;
    {bus_low_raw, input_current_low_raw, quiet} = 3'h0;
    {bus_conn_sense_result, battery_sense_result, die_temp_result} = '0;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    rchk(8'h28, 8'h15);
    rchk(8'h29, 8'h15);
    rchk(8'h2A, 8'hC8);
    rchk(8'h2E, 8'h00);
    rchk(8'h3F, 8'h00);
    $display("defaults test done");
    for (int k = 0; k < 6; k++) begin
      for (int j = 0; j < 3; j++) begin
        lfsr = step(lfsr);
        res[j] = cgar_result_t'(lfsr[15:0]);
      end
      load(res[0], res[1], res[2]);
      rchk(8'h22 + 8'(2 * (k % 3)), {res[k % 3].sign, res[k % 3].mag[14:8]});
      load(~res[0], ~res[1], ~res[2]);
      rchk(8'h23 + 8'(2 * (k % 3)), res[k % 3].mag[7:0]);
    end
    $display("results test done");
    for (int k = 0; k < 6; k++) begin
      lfsr = step(lfsr);
      d = (k == 0) ? 8'hFF : (k == 1) ? 8'hC9 : (k == 2) ? 8'hC8 : lfsr[7:0];
      host.wr(8'h2A, d);
      rchk(8'h2A, clamp(d));
      host.wr(8'h28 + 8'(k % 2), d);
      rchk(8'h28 + 8'(k % 2), d);
    end
    @(posedge core_clk);
    reg_reset <= 1'b1;
    @(posedge core_clk);
    reg_reset <= 1'b0;
    rchk(8'h28, 8'h15);
    rchk(8'h29, 8'h15);
    rchk(8'h2A, 8'hC8);
    rchk(8'h26, 8'h00);
    $display("thresholds test done");
    host.wr(8'h28, 8'h80);
    host.wr(8'h29, 8'h80);
    for (int k = 0; k < 5; k++) begin
      load('{1'b0, 15'(ab[k])}, '{1'b0, 15'(at[k])}, res[2]);
      repeat (3) @(posedge core_clk);
      check(16'(thermal_sense_alarm), 16'(near(ab[k], 8'h80) || near(at[k], 8'h80)), "alarm");
    end
    $display("alarm test done");
    for (int k = 0; k < 8; k++) begin
      lfsr = step(lfsr);
      d = {3'(k), lfsr[4:0]};
      host.wr(8'h2B, d);
      check(16'(ctrl[8:2]), 16'({d[7:5], d[3:0]}), "control");
      check(16'({output_overvolt_protect_en, external_protection_input_pd}), 16'({~d[3], d[0]}), "pins");
      host.wr(8'h2E, lfsr[12:5]);
      check(16'(ctrl[1:0]), 16'(lfsr[9:8]), "deglitch");
    end
    host.wr(8'h2B, 8'h24);
    host.wr(8'h2B, 8'h25);
    repeat (6) @(posedge core_clk);
    check(16'(external_protection_input_pd), 16'h0001, "pd held");
    repeat (2) @(posedge core_clk);
    #1 check(16'(external_protection_input_pd), 16'h0000, "pd end");
    @(posedge core_clk);
    switching_start <= 1'b1;
    repeat (3) @(posedge core_clk);
    host.wr(8'h2B, 8'h20);
    check(16'(ctrl.input_undercurrent_rise_sel), 16'h0001, "refused");
    repeat (24000) @(posedge core_clk);
    check(16'(soft_start_fault), 16'h0000, "early fault");
    repeat (2000) @(posedge core_clk);
    check(16'(soft_start_fault), 16'h0001, "missing fault");
    switching_start <= 1'b0;
    input_bus_current_above <= 1'b1;
    repeat (2) @(posedge core_clk);
    switching_start <= 1'b1;
    repeat (26000) @(posedge core_clk);
    check(16'(soft_start_fault), 16'h0000, "fault with current");
    {switching_start, input_bus_current_above} <= 2'b00;
    $display("control test done");
    quiet <= 1'b1;
    host.wr(8'h2E, 8'h00);
    @(posedge core_clk);
    {bus_low_raw, input_current_low_raw} <= 2'b00;
    repeat (30) @(posedge core_clk);
    {bus_low_raw, input_current_low_raw} <= 2'b11;
    repeat (20) @(posedge core_clk);
    check(16'(dg), 16'h0000, "dg early");
    repeat (3) @(posedge core_clk);
    check(16'(dg), 16'h0003, "dg 10us");
    host.wr(8'h2E, 8'h18);
    @(posedge core_clk);
    {bus_low_raw, input_current_low_raw} <= 2'b00;
    repeat (45) @(posedge core_clk);
    check(16'(dg), 16'h0003, "dg held");
    repeat (15) @(posedge core_clk);
    check(16'(dg), 16'h0002, "dg 5ms");
    repeat (50) @(posedge core_clk);
    check(16'(dg), 16'h0000, "dg 10ms");
    $display("deglitch test done");
    host.wr(8'h2B, 8'h00);
    @(posedge core_clk);
    output_overvolt_condition <= 1'b1;
    repeat (6) @(posedge core_clk);
    rchk(8'h2C, 8'h01);
    rchk(8'h2D, 8'h10);
    rchk(8'h2D, 8'h10);
    check(16'(output_overvolt_irq), 16'h0001, "irq");
    host.wr(8'h2D, 8'h01);
    check(16'(output_overvolt_irq), 16'h0000, "masked irq");
    @(posedge core_clk);
    output_overvolt_condition <= 1'b0;
    repeat (6) @(posedge core_clk);
    rchk(8'h2C, 8'h00);
    rchk(8'h2D, 8'h11);
    rchk(8'h2D, 8'h01);
    $display("overvoltage test done");
    conclude();
  end
endmodule
`default_nettype wire
